// [core/wfec_map.svh]
// Register map, field positions, reset values and timing for the wake counter
`ifndef WFEC_MAP_SVH
`define WFEC_MAP_SVH

`define WFEC_ADDR_RATE   8'h44
`define WFEC_ADDR_COUNT  8'h45
`define WFEC_ADDR_LIMIT  8'h46
`define WFEC_ADDR_DONE   8'h47
`define WFEC_ADDR_FLAG   8'h51
`define WFEC_CFG_LO      8'h30
`define WFEC_CFG_HI      8'h44

`define WFEC_FD_IGN_BIT  7
`define WFEC_NOM_HI      6
`define WFEC_NOM_LO      4
`define WFEC_FAST_HI     3
`define WFEC_FAST_LO     2
`define WFEC_DONE_BIT    7
`define WFEC_OVF_BIT     3

`define WFEC_RATE_RST    8'h50
`define WFEC_NOM_RST     3'h5
`define WFEC_FAST_RST    2'h0
`define WFEC_LIMIT_RST   8'h1F
`define WFEC_ZERO8       8'h00
`define WFEC_ONE8        8'h01

`define WFEC_NOM_50K     3'h0
`define WFEC_NOM_100K    3'h1
`define WFEC_NOM_125K    3'h2
`define WFEC_NOM_250K    3'h3
`define WFEC_NOM_RSV4    3'h4
`define WFEC_NOM_500K    3'h5
`define WFEC_NOM_RSV6    3'h6
`define WFEC_NOM_1M      3'h7
`define WFEC_FAST_X4     2'h0
`define WFEC_FAST_X10    2'h1

`define WFEC_CLK_MHZ     250
`define WFEC_BIT_NS_50K  20000
`define WFEC_BIT_NS_100K 10000
`define WFEC_BIT_NS_125K 8000
`define WFEC_BIT_NS_250K 4000
`define WFEC_BIT_NS_500K 2000
`define WFEC_BIT_NS_1M   1000
`define WFEC_BIT_CYC(ns) (((ns) * `WFEC_CLK_MHZ) / 1000)

`endif

// [core/wfec_pkg.sv]
// Types shared by the wake frame error counter modules
package wfec_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } wfec_reg_req_type;

  typedef struct packed {
    logic done;
    logic err;
    logic fd;
  } wfec_frame_type;

  typedef struct packed {
    logic [7:0] count;
    logic       ovf;
  } wfec_cnt_state_type;

  typedef struct packed {
    logic        fd_ignore;
    logic [2:0]  nom_rate;
    logic [1:0]  fast_ratio;
    logic [7:0]  limit;
    logic        cfg_done;
    logic        ovf_flag;
    logic [7:0]  rdata;
    logic        det_en_q;
    logic        idle_en_q;
    logic [12:0] bit_cyc;
    logic        nom_rsvd;
    logic        fast_rsvd;
  } wfec_state_type;

endpackage : wfec_pkg

// [core/wfec_counter.sv]
// Frame error up/down counter with limit overflow pulse
`timescale 1ns/100ps
`include "wfec_map.svh"
module wfec_counter import wfec_pkg::*; (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       clear_i,
  input  wfec_frame_type  frame_i,
  input  wire logic       fd_ignore_i,
  input  wire logic [7:0] limit_i,
  output logic [7:0]      count_o,
  output logic            overflow_o
);

  wfec_cnt_state_type st;
  wfec_cnt_state_type next_st;
  logic               counted;
  logic               is_err;

  always_comb begin
    next_st = st;
    next_st.ovf = 1'b0;
    // FD frames fall out entirely when ignored
    counted = frame_i.done && !(frame_i.fd && fd_ignore_i);
    // Unignored FD frame counts as an error frame
    is_err = frame_i.err || frame_i.fd;
    if (clear_i) begin
      next_st.count = `WFEC_ZERO8;
    end else if (counted && is_err) begin
      // Holds at the limit; >= covers a limit lowered below the count
      if (st.count >= limit_i) begin
        next_st.ovf = 1'b1;
      end else begin
        next_st.count = 8'(st.count + `WFEC_ONE8);
      end
    end else if (counted && st.count != `WFEC_ZERO8) begin
      next_st.count = 8'(st.count - `WFEC_ONE8);
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign count_o    = st.count;
  assign overflow_o = st.ovf;

  cnt_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    clear_i |=> count_o == `WFEC_ZERO8 && !overflow_o)
    else $error("counter not cleared on enable");

  cnt_inc_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !clear_i && frame_i.done && frame_i.err && !frame_i.fd
    && count_o < limit_i |=> count_o == $past(count_o) + 8'h01)
    else $error("error frame did not add one");

  cnt_dec_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !clear_i && frame_i.done && !frame_i.err && !frame_i.fd
    |=> count_o == (($past(count_o) == 8'h00) ? 8'h00
                    : $past(count_o) - 8'h01))
    else $error("good frame handling wrong");

  fd_ignore_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !clear_i && frame_i.done && frame_i.fd && fd_ignore_i
    |=> $stable(count_o) && !overflow_o)
    else $error("ignored FD frame changed counter");

  fd_error_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !clear_i && frame_i.done && frame_i.fd && !fd_ignore_i
    |=> count_o == $past(count_o) + 8'h01 || overflow_o)
    else $error("FD frame not counted as error");

  ovf_limit_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !clear_i && frame_i.done && frame_i.err && !frame_i.fd
    && count_o == limit_i |=> overflow_o && $stable(count_o))
    else $error("no overflow at limit");

endmodule // wfec_counter

// [core/wfec_top.sv]
// Rate configuration, error limit and overflow flag registers of the wake logic
`timescale 1ns/100ps
`include "wfec_map.svh"
module wfec_top import wfec_pkg::*; #(
  parameter int unsigned BIT_CYC_50K = `WFEC_BIT_CYC(`WFEC_BIT_NS_50K)
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wfec_reg_req_type reg_req_i,
  input  wfec_frame_type   frame_i,
  input  wire logic        frame_detect_en_i,
  input  wire logic        idle_detect_en_i,
  output logic [7:0]       reg_rdata_o,
  output logic             fd_frame_ignore_select_o,
  output logic [2:0]       nominal_rate_select_o,
  output logic [1:0]       fast_rate_ratio_select_o,
  output logic [7:0]       error_count_limit_o,
  output logic [7:0]       frame_error_count_o,
  output logic             error_count_overflow_flag_o,
  output logic             wake_config_done_o,
  output logic [12:0]      nominal_bit_cycles_o,
  output logic             nominal_rate_reserved_o,
  output logic             fast_ratio_reserved_o
);

  localparam logic [12:0] CYC_50K  = 13'(BIT_CYC_50K);
  localparam logic [12:0] CYC_100K =
    13'(`WFEC_BIT_CYC(`WFEC_BIT_NS_100K));
  localparam logic [12:0] CYC_125K =
    13'(`WFEC_BIT_CYC(`WFEC_BIT_NS_125K));
  localparam logic [12:0] CYC_250K =
    13'(`WFEC_BIT_CYC(`WFEC_BIT_NS_250K));
  localparam logic [12:0] CYC_500K =
    13'(`WFEC_BIT_CYC(`WFEC_BIT_NS_500K));
  localparam logic [12:0] CYC_1M   =
    13'(`WFEC_BIT_CYC(`WFEC_BIT_NS_1M));

  wfec_state_type st;
  wfec_state_type next_st;
  logic           cnt_clear;
  logic [7:0]     cnt_value;
  logic           cnt_ovf;
  logic           wr_rate;
  logic           wr_limit;
  logic           wr_done;
  logic           wr_flag;
  logic           wr_cfg;
  logic [7:0]     rate_word;

  // Enable lines come from sibling registers on this clock, so no sync
  assign cnt_clear = (frame_detect_en_i && !st.det_en_q)
                   || (idle_detect_en_i && !st.idle_en_q);

  wfec_counter u_counter (
    .clk_i       (clk_i),
    .rstn_i      (rstn_i),
    .clear_i     (cnt_clear),
    .frame_i     (frame_i),
    .fd_ignore_i (st.fd_ignore),
    .limit_i     (st.limit),
    .count_o     (cnt_value),
    .overflow_o  (cnt_ovf)
  );

  assign wr_rate  = reg_req_i.wr && reg_req_i.addr == `WFEC_ADDR_RATE;
  assign wr_limit = reg_req_i.wr && reg_req_i.addr == `WFEC_ADDR_LIMIT;
  assign wr_done  = reg_req_i.wr && reg_req_i.addr == `WFEC_ADDR_DONE;
  assign wr_flag  = reg_req_i.wr && reg_req_i.addr == `WFEC_ADDR_FLAG;
  // Matching registers below the rate register live elsewhere, yet a
  // write to them must still drop the done bit
  assign wr_cfg   = reg_req_i.wr
                  && ((reg_req_i.addr >= `WFEC_CFG_LO
                       && reg_req_i.addr <= `WFEC_CFG_HI)
                      || reg_req_i.addr == `WFEC_ADDR_LIMIT);

  always_comb begin
    rate_word = `WFEC_ZERO8;
    rate_word[`WFEC_FD_IGN_BIT] = st.fd_ignore;
    rate_word[`WFEC_NOM_HI:`WFEC_NOM_LO] = st.nom_rate;
    rate_word[`WFEC_FAST_HI:`WFEC_FAST_LO] = st.fast_ratio;
  end

  always_comb begin
    next_st = st;
    next_st.det_en_q  = frame_detect_en_i;
    next_st.idle_en_q = idle_detect_en_i;

    if (wr_rate) begin
      next_st.fd_ignore  = reg_req_i.wdata[`WFEC_FD_IGN_BIT];
      next_st.nom_rate   =
        reg_req_i.wdata[`WFEC_NOM_HI:`WFEC_NOM_LO];
      next_st.fast_ratio =
        reg_req_i.wdata[`WFEC_FAST_HI:`WFEC_FAST_LO];
    end

    if (wr_limit) begin
      next_st.limit = reg_req_i.wdata;
    end

    // Done bit: written directly, dropped by any config write
    if (wr_cfg) begin
      next_st.cfg_done = 1'b0;
    end else if (wr_done) begin
      next_st.cfg_done = reg_req_i.wdata[`WFEC_DONE_BIT];
    end

    // Overflow beats a clear in the same cycle so no event is lost
    if (cnt_ovf) begin
      next_st.ovf_flag = 1'b1;
    end else if (wr_flag && reg_req_i.wdata[`WFEC_OVF_BIT]) begin
      next_st.ovf_flag = 1'b0;
    end

    // Bit period in clock cycles; reserved codes give zero
    next_st.nom_rsvd = 1'b0;
    case (st.nom_rate)
      `WFEC_NOM_50K: begin
        next_st.bit_cyc = CYC_50K;
      end
      `WFEC_NOM_100K: begin
        next_st.bit_cyc = CYC_100K;
      end
      `WFEC_NOM_125K: begin
        next_st.bit_cyc = CYC_125K;
      end
      `WFEC_NOM_250K: begin
        next_st.bit_cyc = CYC_250K;
      end
      `WFEC_NOM_500K: begin
        next_st.bit_cyc = CYC_500K;
      end
      `WFEC_NOM_1M: begin
        next_st.bit_cyc = CYC_1M;
      end
      default: begin
        next_st.bit_cyc  = '0;
        next_st.nom_rsvd = 1'b1;
      end
    endcase

    case (st.fast_ratio)
      `WFEC_FAST_X4: begin
        next_st.fast_rsvd = 1'b0;
      end
      `WFEC_FAST_X10: begin
        next_st.fast_rsvd = 1'b0;
      end
      default: begin
        next_st.fast_rsvd = 1'b1;
      end
    endcase

    // Read data lands one cycle after the strobe; unmapped reads zero
    if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        `WFEC_ADDR_RATE: begin
          next_st.rdata = rate_word;
        end
        `WFEC_ADDR_COUNT: begin
          next_st.rdata = cnt_value;
        end
        `WFEC_ADDR_LIMIT: begin
          next_st.rdata = st.limit;
        end
        `WFEC_ADDR_DONE: begin
          next_st.rdata = `WFEC_ZERO8;
          next_st.rdata[`WFEC_DONE_BIT] = st.cfg_done;
        end
        `WFEC_ADDR_FLAG: begin
          next_st.rdata = `WFEC_ZERO8;
          next_st.rdata[`WFEC_OVF_BIT] = st.ovf_flag;
        end
        default: begin
          next_st.rdata = `WFEC_ZERO8;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st            <= '0;
      st.nom_rate   <= `WFEC_NOM_RST;
      st.fast_ratio <= `WFEC_FAST_RST;
      st.limit      <= `WFEC_LIMIT_RST;
      st.bit_cyc    <= CYC_500K;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata_o                 = st.rdata;
  assign fd_frame_ignore_select_o    = st.fd_ignore;
  assign nominal_rate_select_o       = st.nom_rate;
  assign fast_rate_ratio_select_o    = st.fast_ratio;
  assign error_count_limit_o         = st.limit;
  assign frame_error_count_o         = cnt_value;
  assign error_count_overflow_flag_o = st.ovf_flag;
  assign wake_config_done_o          = st.cfg_done;
  assign nominal_bit_cycles_o        = st.bit_cyc;
  assign nominal_rate_reserved_o     = st.nom_rsvd;
  assign fast_ratio_reserved_o       = st.fast_rsvd;

  // Counter cannot be written by software
  count_ro_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    reg_req_i.wr && reg_req_i.addr == `WFEC_ADDR_COUNT
    && !frame_i.done && !cnt_clear |=> $stable(frame_error_count_o))
    else $error("write changed the counter");

  ovf_sticky_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    error_count_overflow_flag_o
    && !(wr_flag && reg_req_i.wdata[`WFEC_OVF_BIT])
    |=> error_count_overflow_flag_o)
    else $error("overflow flag dropped on its own");

  ovf_set_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    cnt_ovf |=> error_count_overflow_flag_o)
    else $error("overflow pulse did not set the flag");

  cfg_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_rate || wr_limit |=> !wake_config_done_o)
    else $error("config write kept done bit");

  limit_wr_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_limit |=> error_count_limit_o == $past(reg_req_i.wdata))
    else $error("limit not stored");

  nom_rsvd_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ##1 nominal_rate_reserved_o ==
      ($past(st.nom_rate) == `WFEC_NOM_RSV4
       || $past(st.nom_rate) == `WFEC_NOM_RSV6))
    else $error("nominal reserved decode wrong");

  fast_rsvd_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ##1 fast_ratio_reserved_o == ($past(st.fast_ratio) > `WFEC_FAST_X10))
    else $error("fast ratio reserved decode wrong");

  rate_read_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    reg_req_i.rd && reg_req_i.addr == `WFEC_ADDR_RATE
    |=> reg_rdata_o[`WFEC_FD_IGN_BIT] == $past(st.fd_ignore)
        && reg_rdata_o[1:0] == 2'h0)
    else $error("rate register read wrong");

  // Every field of the rate register must land where software wrote it
  fd_store_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_rate |=> fd_frame_ignore_select_o
                == $past(reg_req_i.wdata[`WFEC_FD_IGN_BIT]))
    else $error("FD ignore bit not stored");

  nom_store_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_rate |=> nominal_rate_select_o
                == $past(reg_req_i.wdata[`WFEC_NOM_HI:`WFEC_NOM_LO]))
    else $error("nominal rate field not stored");

  fast_store_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_rate |=> fast_rate_ratio_select_o
                == $past(reg_req_i.wdata[`WFEC_FAST_HI:`WFEC_FAST_LO]))
    else $error("fast ratio field not stored");

  done_wr_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    reg_req_i.wr && reg_req_i.addr == `WFEC_ADDR_DONE
    |=> wake_config_done_o == $past(reg_req_i.wdata[`WFEC_DONE_BIT]))
    else $error("done bit write not stored");

  cfg_range_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    reg_req_i.wr && reg_req_i.addr >= `WFEC_CFG_LO
    && reg_req_i.addr <= `WFEC_CFG_HI |=> !wake_config_done_o)
    else $error("matching register write kept done bit");

  cnt_read_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    reg_req_i.rd && reg_req_i.addr == `WFEC_ADDR_COUNT
    |=> reg_rdata_o == $past(frame_error_count_o))
    else $error("counter read wrong");

  limit_read_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    reg_req_i.rd && reg_req_i.addr == `WFEC_ADDR_LIMIT
    |=> reg_rdata_o == $past(error_count_limit_o))
    else $error("limit read wrong");

  flag_read_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    reg_req_i.rd && reg_req_i.addr == `WFEC_ADDR_FLAG
    |=> reg_rdata_o[`WFEC_OVF_BIT] == $past(error_count_overflow_flag_o))
    else $error("overflow flag read wrong");

  flag_clr_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    reg_req_i.wr && reg_req_i.addr == `WFEC_ADDR_FLAG
    && reg_req_i.wdata[`WFEC_OVF_BIT] && !cnt_ovf
    |=> !error_count_overflow_flag_o)
    else $error("overflow flag not cleared by software");

  bit_500k_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    nominal_rate_select_o == `WFEC_NOM_500K
    |=> nominal_bit_cycles_o == CYC_500K)
    else $error("500k bit period wrong");

  bit_1m_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    nominal_rate_select_o == `WFEC_NOM_1M
    |=> nominal_bit_cycles_o == CYC_1M)
    else $error("1M bit period wrong");

  det_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $rose(frame_detect_en_i) |=> frame_error_count_o == `WFEC_ZERO8)
    else $error("detect enable did not zero the counter");

  idle_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $rose(idle_detect_en_i) |=> frame_error_count_o == `WFEC_ZERO8)
    else $error("idle enable did not zero the counter");

endmodule // wfec_top

// [tb/wfec_frame_src.sv]
// Frame event source standing in for the CAN nodes on the bus
`timescale 1ns/100ps
module wfec_frame_src import wfec_pkg::*; (
  input  wire logic      clk_i,
  output wfec_frame_type frame_o
);
  initial frame_o = '{done: 1'b0, err: 1'b1, fd: 1'b1};

  // Qualifiers flip once the frame ends so stale values are never reused
  task automatic send(input logic err, input logic fd);
    @(negedge clk_i);
    frame_o = '{done: 1'b1, err: err, fd: fd};
    @(negedge clk_i);
    frame_o = '{done: 1'b0, err: ~err, fd: ~fd};
  endtask
endmodule // wfec_frame_src

// [tb/tb_wfec_top.sv]
// Self-checking bench for the wake frame error counter block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  error_cnt++; $display("[FAIL] %s exp=%0h got=%0h", nm, e, g); end end
module tb_wfec_top import wfec_pkg::*;;
  logic             clk;
  logic             rstn;
  wfec_reg_req_type req;
  wfec_frame_type   frm;
  logic             det_en;
  logic             idle_en;
  logic [7:0]       rdata;
  logic             fd_ign;
  logic [2:0]       nom;
  logic [1:0]       fast;
  logic [7:0]       limit;
  logic [7:0]       count;
  logic             ovf;
  logic             done;
  logic [12:0]      bit_cyc;
  logic             nom_rsv;
  logic             fast_rsv;
  int               error_cnt;
  int               total_checks;

  wfec_top DUT (
    .clk_i(clk), .rstn_i(rstn), .reg_req_i(req), .frame_i(frm),
    .frame_detect_en_i(det_en), .idle_detect_en_i(idle_en),
    .reg_rdata_o(rdata), .fd_frame_ignore_select_o(fd_ign),
    .nominal_rate_select_o(nom), .fast_rate_ratio_select_o(fast),
    .error_count_limit_o(limit), .frame_error_count_o(count),
    .error_count_overflow_flag_o(ovf), .wake_config_done_o(done),
    .nominal_bit_cycles_o(bit_cyc), .nominal_rate_reserved_o(nom_rsv),
    .fast_ratio_reserved_o(fast_rsv)
  );
  wfec_frame_src SRC (.clk_i(clk), .frame_o(frm));

  initial clk = 1'b0;
  always #2 clk = ~clk;

  task automatic close_out;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req.wr = 1'b0;
  endtask

  // Read data is taken one cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    req.rd = 1'b0;
    `CHK("rdata", e, rdata)
  endtask

  task automatic t_reset;
    `CHK("nom_rst", 3'h5, nom)
    `CHK("fast_rst", 2'h0, fast)
    `CHK("bitcyc_rst", 13'h01F4, bit_cyc)
    rd_chk(8'h44, 8'h50);
    rd_chk(8'h45, 8'h00);
    rd_chk(8'h46, 8'h1F);
    rd_chk(8'h47, 8'h00);
    rd_chk(8'h51, 8'h00);
    rd_chk(8'h60, 8'h00);
  endtask

  task automatic t_done;
    logic [7:0] adr [3] = '{8'h30, 8'h44, 8'h46};
    logic [7:0] val [3] = '{8'h00, 8'h50, 8'h1F};
    for (int i = 0; i < 3; i++) begin
      wr_reg(8'h47, 8'h80);
      `CHK("done_set", 1'b1, done)
      wr_reg(adr[i], val[i]);
      `CHK("done_clr", 1'b0, done)
    end
  endtask

  task automatic t_rate;
    logic [12:0] cyc [8] = '{13'h1388, 13'h09C4, 13'h07D0, 13'h03E8,
                             13'h0000, 13'h01F4, 13'h0000, 13'h00FA};
    logic [7:0]  v;
    for (int n = 0; n < 8; n++) begin
      v = {n[0], n[2:0], n[1:0], 2'h0};
      wr_reg(8'h44, v | 8'h03);
      rd_chk(8'h44, v);
      `CHK("fd_ign", n[0], fd_ign)
      `CHK("nom", n[2:0], nom)
      `CHK("fast", n[1:0], fast)
      `CHK("bitcyc", cyc[n], bit_cyc)
      `CHK("nom_rsv", (n == 4 || n == 6), nom_rsv)
      `CHK("fast_rsv", n[1], fast_rsv)
    end
    wr_reg(8'h44, 8'h50);
  endtask

  task automatic t_count;
    SRC.send(1'b0, 1'b0);
    `CHK("cnt_floor", 8'h00, count)
    for (int i = 1; i <= 31; i++) begin
      SRC.send(1'b1, 1'b0);
      `CHK("cnt_up", 8'(i), count)
    end
    `CHK("ovf_early", 1'b0, ovf)
    SRC.send(1'b1, 1'b0);
    @(negedge clk);
    `CHK("ovf_32nd", 1'b1, ovf)
    `CHK("cnt_hold", 8'h1F, count)
    repeat (3) @(negedge clk);
    `CHK("ovf_sticky", 1'b1, ovf)
    rd_chk(8'h51, 8'h08);
    wr_reg(8'h51, 8'h08);
    `CHK("ovf_w1c", 1'b0, ovf)
    wr_reg(8'h45, 8'h00);
    `CHK("cnt_ro", 8'h1F, count)
    SRC.send(1'b0, 1'b0);
    `CHK("cnt_down", 8'h1E, count)
    SRC.send(1'b0, 1'b1);
    `CHK("fd_as_err", 8'h1F, count)
    wr_reg(8'h44, 8'hD0);
    SRC.send(1'b1, 1'b1);
    `CHK("fd_ign_err", 8'h1F, count)
    SRC.send(1'b0, 1'b1);
    `CHK("fd_ign_ok", 8'h1F, count)
    SRC.send(1'b0, 1'b0);
    `CHK("ign_good", 8'h1E, count)
    wr_reg(8'h44, 8'h50);
  endtask

  task automatic t_clear;
    @(negedge clk);
    det_en = 1'b1;
    @(negedge clk);
    `CHK("clr_det", 8'h00, count)
    SRC.send(1'b1, 1'b0);
    SRC.send(1'b1, 1'b0);
    `CHK("cnt_two", 8'h02, count)
    idle_en = 1'b1;
    @(negedge clk);
    `CHK("clr_idle", 8'h00, count)
  endtask

  // A small limit exposes off-by-one in the overflow compare
  task automatic t_limit;
    wr_reg(8'h46, 8'h02);
    rd_chk(8'h46, 8'h02);
    `CHK("limit_o", 8'h02, limit)
    SRC.send(1'b1, 1'b0);
    SRC.send(1'b1, 1'b0);
    @(negedge clk);
    `CHK("ovf_at_lim", 1'b0, ovf)
    SRC.send(1'b1, 1'b0);
    @(negedge clk);
    `CHK("ovf_next", 1'b1, ovf)
    `CHK("cnt_lim", 8'h02, count)
  endtask

  // Reset in mid-run must restore every register, not only the counter
  task automatic t_rst_mid;
    wr_reg(8'h44, 8'hF4);
    wr_reg(8'h47, 8'h80);
    `CHK("pre_done", 1'b1, done)
    `CHK("pre_ovf", 1'b1, ovf)
    `CHK("pre_cyc", 13'h00FA, bit_cyc)
    @(negedge clk);
    rstn = 1'b0;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    `CHK("mid_fd", 1'b0, fd_ign)
    `CHK("mid_nom", 3'h5, nom)
    `CHK("mid_fast", 2'h0, fast)
    `CHK("mid_cyc", 13'h01F4, bit_cyc)
    `CHK("mid_limit", 8'h1F, limit)
    `CHK("mid_cnt", 8'h00, count)
    `CHK("mid_ovf", 1'b0, ovf)
    `CHK("mid_done", 1'b0, done)
    `CHK("mid_rdata", 8'h00, rdata)
    rd_chk(8'h44, 8'h50);
    SRC.send(1'b1, 1'b0);
    `CHK("mid_cnt_up", 8'h01, count)
  endtask

  initial begin
    error_cnt = 0;
    total_checks = 0;
    rstn = 1'b0;
    req = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};
    det_en = 1'b0;
    idle_en = 1'b0;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    t_reset();
    t_done();
    t_rate();
    t_count();
    t_clear();
    t_limit();
    t_rst_mid();
    close_out();
  end

  // Whole run needs under two hundred cycles; this leaves wide margin
  initial begin
    #200000;
    error_cnt++;
    close_out();
  end
endmodule // tb_wfec_top
